// *** hdl/ctrl_port_pkg.sv ***
// Constants, register layout and state type for the serial mode-control port.
// Assumes a single 50 MHz system clock; all pins arrive asynchronously.
package ctrl_port_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int DIR_POS = 15;
  localparam int IDX_MSB = 14;
  localparam int IDX_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int HIZ_BITS = 8;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_OVER = 5'h11;

  // ----------------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam logic [6:0] IDX_RSVD_LOW = 7'h00;
  localparam logic [6:0] IDX_ATTEN_FIRST = 7'h01;
  localparam logic [6:0] IDX_ATTEN_LAST = 7'h06;
  localparam logic [6:0] IDX_LOAD_RATE_MUTE = 7'h07;
  localparam logic [6:0] IDX_CONV_ZERO = 7'h08;
  localparam logic [6:0] IDX_FMT_FLT_CLK = 7'h09;
  localparam logic [6:0] IDX_DEEMPH = 7'h0a;
  localparam logic [6:0] IDX_READBACK = 7'h0b;
  localparam logic [6:0] IDX_RSVD_HIGH = 7'h0c;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LOAD_EN_POS = 7;
  localparam int RAMP_RATE_POS = 6;
  localparam int ZERO_MUTE_POS = 6;
  localparam int FILTER_POS = 5;
  localparam int CLK_DIV_POS = 4;
  localparam int CLK_DIS_POS = 3;
  localparam int FMT_MSB = 2;
  localparam int DMF_MSB = 4;
  localparam int DMF_LSB = 3;
  localparam int DM_MSB = 2;
  localparam int SEQ_EN_POS = 7;
  localparam int RB_IDX_MSB = 6;

  // ----------------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] ATTEN_RESET = 8'hff;
  localparam logic [7:0] LOAD_RATE_MUTE_RESET = 8'h00;
  localparam logic [7:0] CONV_ZERO_RESET = 8'h00;
  localparam logic [7:0] FMT_FLT_CLK_RESET = 8'h00;
  localparam logic [7:0] DEEMPH_RESET = 8'h00;
  localparam logic [7:0] READBACK_RESET = 8'h01;
  localparam logic [7:0] CONV_ZERO_MASK = 8'h7f;
  localparam logic [7:0] FMT_FLT_CLK_MASK = 8'h3f;
  localparam logic [7:0] DEEMPH_MASK = 8'h1f;
  localparam logic [7:0] MUTE_LIMIT = 8'h80;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int INIT_CYCLES = 1024;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic sck_m, sck_s, sck_d;
    logic lat_m, lat_s, lat_d;
    logic din_m, din_s;
    logic [10:0] init_cnt;
    logic ready;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic is_read;
    logic seq;
    logic [6:0] last_idx;
    logic [6:0] cur_idx;
    logic [2:0] ocnt;
    logic done;
    logic sdo;
    logic oe_n;
    logic [NUM_CH-1:0][7:0] atten;
    logic [NUM_CH-1:0][7:0] eff;
    logic [NUM_CH-1:0] mute;
    logic [7:0] r7, r8, r9, r10, r11;
  } port_state_t;

endpackage

// *** hdl/dac_serial_mode_control_port.sv ***
// Serial mode-control port with its mode-register bank.
// Assumes strobe, bit clock and serial input come from a host on another clock;
// the output enable pin is resolved outside.
`timescale 1ns/1ps

// Operation
// - Sixteen-bit command word, most significant bit first
// - Bit fifteen zero writes, one reads
// - Bits 14..8 index, bits 7..0 payload
// - Strobe rise after sixteen bits commits payload
// - Reads use readback index, not command index
// - Single read: eight clocks idle, eight data
// - Sequential read returns registers one through N
// - Sequential read starts at next strobe fall
// - Input after command ignored while strobe low
// - Sequential: eight idle clocks, then bytes 1..N
// - Reset: readback index one, sequential off
// - Reset: all function bits at defaults
// - Attenuation bytes reset to all ones
// - Byte 129..255 half-dB steps, else mute
// - Shared load enable gates attenuation changes
// - Port runs only from its own bit clock; here the bit clock is sampled on the system clock
// - Init 1024 clocks, then load defaults
// - Clearing load enable discards attenuator data
module dac_serial_mode_control_port
  import ctrl_port_pkg::*;
#(
  parameter int INIT_LEN = INIT_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic frame_latch_strobe,
  input wire logic ctrl_bit_clock,
  input wire logic ctrl_serial_in,
  output logic ctrl_serial_out,
  output logic ctrl_serial_out_oe_n,
  output logic ctrl_ready,
  output logic [NUM_CH-1:0][7:0] atten_level_byte,
  output logic [NUM_CH-1:0] atten_mute,
  output logic atten_load_enable,
  output logic atten_ramp_rate,
  output logic [NUM_CH-1:0] soft_mute_bit,
  output logic zero_detect_mute_enable,
  output logic [NUM_CH-1:0] converter_disable_bit,
  output logic [2:0] audio_format_select,
  output logic filter_rolloff_select,
  output logic clock_out_divide,
  output logic clock_out_disable,
  output logic [1:0] deemph_rate_select,
  output logic [2:0] deemph_enable
);

  // ----------------------------------------------------------------------
  // Register readback decode
  // ----------------------------------------------------------------------
  function automatic logic [7:0] read_reg(input port_state_t s, input logic [6:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx >= IDX_ATTEN_FIRST && idx <= IDX_ATTEN_LAST) begin
      v = s.atten[3'(idx - IDX_ATTEN_FIRST)];
    end else if (idx == IDX_LOAD_RATE_MUTE) begin
      v = s.r7;
    end else if (idx == IDX_CONV_ZERO) begin
      v = s.r8;
    end else if (idx == IDX_FMT_FLT_CLK) begin
      v = s.r9;
    end else if (idx == IDX_DEEMPH) begin
      v = s.r10;
    end else if (idx == IDX_READBACK) begin
      v = s.r11;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  port_state_t st_r;
  port_state_t st_nxt;
  logic sck_rise;
  logic sck_fall;
  logic lat_fall;
  logic lat_rise;
  logic [7:0] rd_byte;
  logic [6:0] wr_idx;
  logic [7:0] wr_data;

  assign sck_rise = st_r.sck_s & ~st_r.sck_d;
  assign sck_fall = ~st_r.sck_s & st_r.sck_d;
  assign lat_fall = ~st_r.lat_s & st_r.lat_d;
  assign lat_rise = st_r.lat_s & ~st_r.lat_d;
  assign rd_byte = read_reg(st_r, st_r.cur_idx);
  assign wr_idx = st_r.sh[IDX_MSB:IDX_LSB];
  assign wr_data = st_r.sh[DATA_MSB:0];

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Pins pass two flops before use; edges compare the second with a third delayed copy
    st_nxt.sck_m = ctrl_bit_clock;
    st_nxt.sck_s = st_r.sck_m;
    st_nxt.sck_d = st_r.sck_s;
    st_nxt.lat_m = frame_latch_strobe;
    st_nxt.lat_s = st_r.lat_m;
    st_nxt.lat_d = st_r.lat_s;
    st_nxt.din_m = ctrl_serial_in;
    st_nxt.din_s = st_r.din_m;

    if (!st_r.ready) begin
      // Port is deaf during initialisation, then defaults are loaded
      if (st_r.init_cnt == 11'(INIT_LEN - 1)) begin
        st_nxt.ready = 1'b1;
        st_nxt.atten = {NUM_CH{ATTEN_RESET}};
        st_nxt.eff = {NUM_CH{ATTEN_RESET}};
        st_nxt.r7 = LOAD_RATE_MUTE_RESET;
        st_nxt.r8 = CONV_ZERO_RESET;
        st_nxt.r9 = FMT_FLT_CLK_RESET;
        st_nxt.r10 = DEEMPH_RESET;
        st_nxt.r11 = READBACK_RESET;
      end else begin
        st_nxt.init_cnt = st_r.init_cnt + 11'h001;
      end
    end else begin
      if (lat_fall) begin
        // New frame; read source fixed from readback control now
        st_nxt.cnt = 5'h00;
        st_nxt.is_read = 1'b0;
        st_nxt.done = 1'b0;
        st_nxt.ocnt = 3'h0;
        st_nxt.oe_n = 1'b1;
        st_nxt.seq = st_r.r11[SEQ_EN_POS];
        st_nxt.last_idx = st_r.r11[RB_IDX_MSB:0];
        st_nxt.cur_idx = st_r.r11[SEQ_EN_POS] ? IDX_ATTEN_FIRST : st_r.r11[RB_IDX_MSB:0];
      end else if (lat_rise) begin
        st_nxt.oe_n = 1'b1;
        st_nxt.done = 1'b1;
        // Commit only a write of exactly sixteen bits
        if (!st_r.is_read && st_r.cnt == CNT_FULL) begin
          if (wr_idx >= IDX_ATTEN_FIRST && wr_idx <= IDX_ATTEN_LAST) begin
            st_nxt.atten[3'(wr_idx - IDX_ATTEN_FIRST)] = wr_data;
          end else if (wr_idx == IDX_LOAD_RATE_MUTE) begin
            st_nxt.r7 = wr_data;
          end else if (wr_idx == IDX_CONV_ZERO) begin
            st_nxt.r8 = wr_data & CONV_ZERO_MASK;
          end else if (wr_idx == IDX_FMT_FLT_CLK) begin
            st_nxt.r9 = wr_data & FMT_FLT_CLK_MASK;
          end else if (wr_idx == IDX_DEEMPH) begin
            st_nxt.r10 = wr_data & DEEMPH_MASK;
          end else if (wr_idx == IDX_READBACK) begin
            st_nxt.r11 = wr_data;
          end
        end
      end else if (!st_r.lat_s) begin
        if (sck_rise) begin
          // Sample on rising edge; bits past the command are dropped
          if (st_r.cnt < CNT_FULL) begin
            st_nxt.sh = {st_r.sh[14:0], st_r.din_s};
            st_nxt.cnt = st_r.cnt + 5'h01;
            if (st_r.cnt == 5'h00) begin
              st_nxt.is_read = st_r.din_s;
            end
          end else if (!st_r.is_read) begin
            st_nxt.cnt = CNT_OVER;
          end
        end else if (sck_fall) begin
          // Output changes on falling edge after the eighth bit
          if (st_r.is_read && st_r.cnt >= 5'(HIZ_BITS) && !st_r.done) begin
            st_nxt.oe_n = 1'b0;
            st_nxt.sdo = rd_byte[3'(7 - st_r.ocnt)];
            st_nxt.ocnt = st_r.ocnt + 3'h1;
            if (st_r.ocnt == 3'h7) begin
              if (!st_r.seq || st_r.cur_idx >= st_r.last_idx) begin
                st_nxt.done = 1'b1;
              end else begin
                st_nxt.cur_idx = st_r.cur_idx + 7'h01;
              end
            end
          end else begin
            st_nxt.oe_n = 1'b1;
          end
        end
      end
    end

    // Attenuators follow the level bytes only while loading is enabled
    for (int i = 0; i < NUM_CH; i++) begin
      if (st_r.r7[LOAD_EN_POS]) begin
        st_nxt.eff[i] = st_r.atten[i];
      end else begin
        st_nxt.eff[i] = ATTEN_RESET;
      end
      st_nxt.mute[i] = (st_r.eff[i] <= MUTE_LIMIT);
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{sck_m: 1'b0, sck_s: 1'b0, sck_d: 1'b0, lat_m: 1'b1, lat_s: 1'b1, lat_d: 1'b1,
                din_m: 1'b0, din_s: 1'b0, init_cnt: 11'h000, ready: 1'b0, cnt: 5'h00, sh: 16'h0000,
                is_read: 1'b0, seq: 1'b0, last_idx: 7'h00, cur_idx: 7'h00, ocnt: 3'h0, done: 1'b1,
                sdo: 1'b0, oe_n: 1'b1, atten: {NUM_CH{ATTEN_RESET}}, eff: {NUM_CH{ATTEN_RESET}},
                mute: '0, r7: LOAD_RATE_MUTE_RESET, r8: CONV_ZERO_RESET, r9: FMT_FLT_CLK_RESET,
                r10: DEEMPH_RESET, r11: READBACK_RESET};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign ctrl_serial_out = st_r.sdo;
  assign ctrl_serial_out_oe_n = st_r.oe_n;
  assign ctrl_ready = st_r.ready;
  assign atten_level_byte = st_r.eff;
  assign atten_mute = st_r.mute;
  assign atten_load_enable = st_r.r7[LOAD_EN_POS];
  assign atten_ramp_rate = st_r.r7[RAMP_RATE_POS];
  assign soft_mute_bit = st_r.r7[NUM_CH-1:0];
  assign zero_detect_mute_enable = st_r.r8[ZERO_MUTE_POS];
  assign converter_disable_bit = st_r.r8[NUM_CH-1:0];
  assign audio_format_select = st_r.r9[FMT_MSB:0];
  assign filter_rolloff_select = st_r.r9[FILTER_POS];
  assign clock_out_divide = st_r.r9[CLK_DIV_POS];
  assign clock_out_disable = st_r.r9[CLK_DIS_POS];
  assign deemph_rate_select = st_r.r10[DMF_MSB:DMF_LSB];
  assign deemph_enable = st_r.r10[DM_MSB:0];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  hiz_first_eight_a: assert property (st_r.ready && st_r.cnt < 5'h08 |-> st_r.oe_n)
    else $error("Serial output driven before ninth bit");

  oe_idle_a: assert property (!st_r.ready |-> st_r.oe_n)
    else $error("Serial output driven during initialisation");

  read_drive_a: assert property (clk_en && st_r.ready && !st_r.lat_s && !lat_fall && sck_fall && st_r.is_read
      && st_r.cnt >= 5'(HIZ_BITS) && !st_r.done |=> !st_r.oe_n)
    else $error("Read data not driven");

  write_commit_a: assert property (clk_en && st_r.ready && lat_rise && !st_r.is_read && st_r.cnt == CNT_FULL
      && wr_idx == IDX_READBACK |=> st_r.r11 == $past(wr_data))
    else $error("Write frame did not reach register");

  atten_write_a: assert property (clk_en && st_r.ready && lat_rise && !st_r.is_read && st_r.cnt == CNT_FULL
      && wr_idx == IDX_ATTEN_FIRST |=> st_r.atten[0] == $past(wr_data))
    else $error("Level byte write lost");

  read_no_write_a: assert property (clk_en && st_r.ready && lat_rise && st_r.is_read
      |=> $stable(st_r.atten) && $stable(st_r.r7) && $stable(st_r.r11))
    else $error("Read frame changed a register");

  short_frame_a: assert property (clk_en && st_r.ready && lat_rise && st_r.cnt != CNT_FULL
      |=> $stable(st_r.atten) && $stable(st_r.r7) && $stable(st_r.r11))
    else $error("Short frame changed a register");

  // ----------------------------------------------------------------------
  // Frame assertions
  // ----------------------------------------------------------------------

  frame_open_a: assert property (clk_en && st_r.ready && lat_fall |=> st_r.cnt == 5'h00 && st_r.oe_n)
    else $error("Frame not opened on strobe fall");

  dir_capture_a: assert property (clk_en && st_r.ready && !st_r.lat_s && !lat_fall && sck_rise
      && st_r.cnt == 5'h00 |=> st_r.is_read == $past(st_r.din_s))
    else $error("Direction bit not captured");

  shift_in_a: assert property (clk_en && st_r.ready && !st_r.lat_s && !lat_fall && sck_rise
      && st_r.cnt < CNT_FULL |=> st_r.sh == {$past(st_r.sh[14:0]), $past(st_r.din_s)})
    else $error("Command bit not shifted in");

  oe_edge_a: assert property (clk_en && st_r.ready && !sck_fall && !lat_fall && !lat_rise
      |=> $stable(st_r.oe_n))
    else $error("Output enable moved off a falling edge");

  sdo_edge_a: assert property (clk_en && st_r.ready && !sck_fall |=> $stable(st_r.sdo))
    else $error("Serial output moved off a falling edge");

  read_index_a: assert property (clk_en && st_r.ready && lat_fall && !st_r.r11[SEQ_EN_POS]
      |=> st_r.cur_idx == $past(st_r.r11[RB_IDX_MSB:0]))
    else $error("Single read not using readback index");

  seq_advance_a: assert property (clk_en && st_r.ready && !st_r.lat_s && !lat_fall && sck_fall && st_r.is_read
      && st_r.cnt >= 5'(HIZ_BITS) && !st_r.done && st_r.seq && st_r.ocnt == 3'h7 && st_r.cur_idx < st_r.last_idx
      |=> st_r.cur_idx == $past(st_r.cur_idx) + 7'h01)
    else $error("Sequential read did not advance");

  // ----------------------------------------------------------------------
  // Register assertions
  // ----------------------------------------------------------------------

  init_length_a: assert property ($rose(st_r.ready) |-> $past(st_r.init_cnt) == 11'(INIT_LEN - 1))
    else $error("Initialisation length wrong");

  reset_defaults_a: assert property ($rose(st_r.ready) |-> st_r.r11 == READBACK_RESET
      && st_r.r9 == FMT_FLT_CLK_RESET && st_r.atten == {NUM_CH{ATTEN_RESET}})
    else $error("Defaults not loaded after initialisation");

  reserved_zero_a: assert property (st_r.ready |-> (st_r.r8 & ~CONV_ZERO_MASK) == 8'h00
      && (st_r.r9 & ~FMT_FLT_CLK_MASK) == 8'h00 && (st_r.r10 & ~DEEMPH_MASK) == 8'h00)
    else $error("Reserved register bit set");

  load_gate_a: assert property (clk_en && !st_r.r7[LOAD_EN_POS] |=> st_r.eff == {NUM_CH{ATTEN_RESET}})
    else $error("Attenuator data kept while load disabled");

  load_follow_a: assert property (clk_en && st_r.r7[LOAD_EN_POS] |=> st_r.eff == $past(st_r.atten))
    else $error("Attenuator not following level byte");

  mute_map_a: assert property (clk_en |=> st_r.mute[0] == ($past(st_r.eff[0]) <= MUTE_LIMIT))
    else $error("Mute decode wrong");

  seq_start_a: assert property (clk_en && st_r.ready && lat_fall && st_r.r11[SEQ_EN_POS]
      |=> st_r.cur_idx == IDX_ATTEN_FIRST)
    else $error("Sequential read not starting at one");

  ignore_tail_a: assert property (clk_en && st_r.ready && !st_r.lat_s && !lat_rise && st_r.cnt == CNT_FULL
      |=> $stable(st_r.sh))
    else $error("Input taken after command word");

  write_seen_c: cover property (lat_rise && !st_r.is_read && st_r.cnt == CNT_FULL);
  read_drive_c: cover property (!st_r.oe_n && !st_r.seq);
  seq_step_c: cover property (st_r.seq && st_r.cur_idx > IDX_ATTEN_FIRST && !st_r.oe_n);
  short_seen_c: cover property (st_r.ready && lat_rise && st_r.cnt != CNT_FULL);
  init_done_c: cover property ($rose(st_r.ready));

endmodule // dac_serial_mode_control_port

// *** verif/host_link_model.sv ***
// Host-side model of the serial control link: strobe, bit clock and serial input.
// Assumes one system clock; the bit clock stands still low between frames.
`timescale 1ns/1ps
module host_link_model (
  input wire logic clock,
  input wire logic link_out,
  input wire logic link_out_oe_n,
  output logic frame_latch_strobe,
  output logic ctrl_bit_clock,
  output logic ctrl_serial_in
);
  logic [7:0] rd_q[$];
  int oe_errors;

  initial begin
    frame_latch_strobe = 1'b1;
    ctrl_bit_clock = 1'b0;
    ctrl_serial_in = 1'b0;
    oe_errors = 0;
  end

  // ----------------------------------------------------------------------
  // One frame: nbits clocks, (nbits-8)/8 bytes taken after eight idle clocks when nread > 0
  // ----------------------------------------------------------------------
  task automatic run_frame(input logic [15:0] cmd, input int nbits, input int nread);
    logic [7:0] byte_v;
    byte_v = 8'h00;
    rd_q.delete();
    @(posedge clock);
    frame_latch_strobe <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < nbits; i++) begin
      ctrl_serial_in <= (i < 16) ? cmd[15 - i] : 1'b1;
      repeat (5) @(posedge clock);
      ctrl_bit_clock <= 1'b1;
      #1;
      if (nread > 0 && i >= 8) begin
        byte_v = {byte_v[6:0], link_out};
        if (link_out_oe_n !== 1'b0) oe_errors++;
        if (i % 8 == 7) rd_q.push_back(byte_v);
      end else if (link_out_oe_n !== 1'b1) oe_errors++;
      repeat (3) @(posedge clock);
      ctrl_bit_clock <= 1'b0;
    end
    repeat (5) @(posedge clock);
    frame_latch_strobe <= 1'b1;
    ctrl_serial_in <= ~ctrl_serial_in;
    repeat (8) @(posedge clock);
  endtask
endmodule // host_link_model

// *** verif/tb.sv ***
// Testbench for the serial mode-control port.
// Assumes the host model drives the link and the design runs with a short init.
`timescale 1ns/1ps
module tb;
  import ctrl_port_pkg::*;
  localparam int INIT_SHORT = 8;
  logic clock, sys_rst, clk_en;
  logic frame_latch_strobe, ctrl_bit_clock, ctrl_serial_in;
  logic ctrl_serial_out, ctrl_serial_out_oe_n, ctrl_ready, atten_load_enable, atten_ramp_rate;
  logic zero_detect_mute_enable, filter_rolloff_select, clock_out_divide, clock_out_disable;
  logic [NUM_CH-1:0][7:0] atten_level_byte;
  logic [NUM_CH-1:0] atten_mute, soft_mute_bit, converter_disable_bit;
  logic [2:0] audio_format_select, deemph_enable;
  logic [1:0] deemph_rate_select;
  wire sdo_line;
  int errors, cmp_count;
  logic [7:0] seqx [10] = '{8'hff, 8'hfe, 8'h81, 8'h80, 8'h00, 8'hc3, 8'hea, 8'h29, 8'h25, 8'h12};

  assign sdo_line = ctrl_serial_out_oe_n ? 1'bz : ctrl_serial_out;

  dac_serial_mode_control_port #(.INIT_LEN(INIT_SHORT)) dac_serial_mode_control_port_i (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .frame_latch_strobe(frame_latch_strobe),
    .ctrl_bit_clock(ctrl_bit_clock), .ctrl_serial_in(ctrl_serial_in), .ctrl_serial_out(ctrl_serial_out),
    .ctrl_serial_out_oe_n(ctrl_serial_out_oe_n), .ctrl_ready(ctrl_ready), .atten_level_byte(atten_level_byte),
    .atten_mute(atten_mute), .atten_load_enable(atten_load_enable), .atten_ramp_rate(atten_ramp_rate),
    .soft_mute_bit(soft_mute_bit), .zero_detect_mute_enable(zero_detect_mute_enable),
    .converter_disable_bit(converter_disable_bit), .audio_format_select(audio_format_select),
    .filter_rolloff_select(filter_rolloff_select), .clock_out_divide(clock_out_divide),
    .clock_out_disable(clock_out_disable), .deemph_rate_select(deemph_rate_select),
    .deemph_enable(deemph_enable));

  host_link_model host_link_model_i (
    .clock(clock), .link_out(sdo_line), .link_out_oe_n(ctrl_serial_out_oe_n),
    .frame_latch_strobe(frame_latch_strobe), .ctrl_bit_clock(ctrl_bit_clock), .ctrl_serial_in(ctrl_serial_in));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic write_reg(input logic [6:0] idx, input logic [7:0] val);
    host_link_model_i.run_frame({1'b0, idx, val}, 16, 0);
  endtask

  task automatic read_one(input logic [6:0] idx, input logic [7:0] exp);
    write_reg(IDX_READBACK, {1'b0, idx});
    host_link_model_i.run_frame(16'h8000, 16, 1);
    chk("single read", exp, host_link_model_i.rd_q[0]);
  endtask

  task automatic do_reset();
    int n;
    n = 0;
    sys_rst <= 1'b1;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    while (ctrl_ready !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("init length", INIT_SHORT, n);
    repeat (4) @(posedge clock);
  endtask

  task automatic check_defaults();
    chk("atten", {NUM_CH{8'hff}}, atten_level_byte);
    chk("mute", '0, atten_mute);
    chk("reg7 outs", 8'h00, {atten_load_enable, atten_ramp_rate, soft_mute_bit});
    chk("reg8 outs", 7'h00, {zero_detect_mute_enable, converter_disable_bit});
    chk("reg9 outs", 6'h00, {filter_rolloff_select, clock_out_divide, clock_out_disable, audio_format_select});
    chk("reg10 outs", 5'h00, {deemph_rate_select, deemph_enable});
    host_link_model_i.run_frame(16'h8000, 16, 1);
    chk("default read", 8'hff, host_link_model_i.rd_q[0]);
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    errors = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    do_reset();
    check_defaults();
    write_reg(IDX_ATTEN_FIRST, 8'h90);
    chk("atten gated", 8'hff, atten_level_byte[0]);
    write_reg(IDX_LOAD_RATE_MUTE, 8'h80);
    for (int c = 0; c < NUM_CH; c++) write_reg(IDX_ATTEN_FIRST + 7'(c), seqx[c]);
    for (int c = 0; c < NUM_CH; c++) begin
      chk("atten ch", seqx[c], atten_level_byte[c]);
      chk("mute ch", seqx[c] <= 8'h80, atten_mute[c]);
    end
    write_reg(IDX_LOAD_RATE_MUTE, 8'hea);
    write_reg(IDX_CONV_ZERO, 8'ha9);
    write_reg(IDX_FMT_FLT_CLK, 8'he5);
    write_reg(IDX_DEEMPH, 8'hf2);
    chk("reg7 outs", 8'hea, {atten_load_enable, atten_ramp_rate, soft_mute_bit});
    chk("reg8 outs", 7'h29, {zero_detect_mute_enable, converter_disable_bit});
    chk("reg9 outs", 6'h25, {filter_rolloff_select, clock_out_divide, clock_out_disable, audio_format_select});
    chk("reg10 outs", 5'h12, {deemph_rate_select, deemph_enable});
    write_reg(IDX_READBACK, 8'h8a);
    host_link_model_i.run_frame(16'h8000, 88, 10);
    for (int k = 0; k < 10; k++) chk("seq read", seqx[k], host_link_model_i.rd_q[k]);
    read_one(IDX_READBACK, 8'h0b);
    host_link_model_i.run_frame({1'b0, IDX_LOAD_RATE_MUTE, 8'h00}, 15, 0);
    chk("short frame", 8'hea, {atten_load_enable, atten_ramp_rate, soft_mute_bit});
    write_reg(7'h0d, 8'h55);
    read_one(7'h0d, 8'h00);
    write_reg(IDX_LOAD_RATE_MUTE, 8'h00);
    chk("atten off", {NUM_CH{8'hff}}, atten_level_byte);
    chk("mute off", '0, atten_mute);
    do_reset();
    check_defaults();
    chk("read oe", 0, host_link_model_i.oe_errors);
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    report_and_stop();
  end
endmodule // tb
